// ===== pkg/pcs_params.svh
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
// command signatures written by the master
`define PCS_SIG_SAVE     32'h65766173
`define PCS_SIG_DISCARD  32'h64616f6c
// value left in a save subindex once the save is done
`define PCS_DONE_VAL     32'h00000001
// subindex to category mapping
`define PCS_SUB_ALL      8'h01
`define PCS_SUB_COMM     8'h02
`define PCS_SUB_APPL     8'h03
`define PCS_SUB_CUST     8'h04
`define PCS_SUB_DRIVE    8'h05
`define PCS_SUB_TUNE     8'h06
// category bit positions in a category mask
`define PCS_CAT_COMM     0
`define PCS_CAT_APPL     1
`define PCS_CAT_CUST     2
`define PCS_CAT_DRIVE    3
`define PCS_CAT_TUNE     4
// masks for the "all" subindex
`define PCS_MASK_ALL     5'h1f
`define PCS_MASK_FACTORY 5'h0f
`define PCS_MASK_NONE    5'h00
// marker cleared value
`define PCS_MARK_CLR     32'h00000000
// object indices of the command and marker entries
`define PCS_IDX_SAVE     16'h1010
`define PCS_IDX_DISCARD  16'h1011
`define PCS_IDX_MARKER   16'h1020
// marker subindices
`define PCS_MARK_SUB0    8'h01
`define PCS_MARK_SUB1    8'h02
// objects whose category membership is fixed inside this block
`define PCS_OBJ_OLCR_IDLE  16'h2036
`define PCS_OBJ_OLCR_VAL   16'h2037
`define PCS_OBJ_BRAKE      16'h2038
`define PCS_OBJ_CTRLWORD   16'h6040
`define PCS_OBJ_OPMODE     16'h6060
`define PCS_OBJ_HOMING     16'h6098
`define PCS_OBJ_MAXACC     16'h60c5
`define PCS_OBJ_DOUT       16'h60fe
`define PCS_OBJ_SUBMODE    16'h3202
`define PCS_OBJ_POLE_PAIRS 16'h2030
`define PCS_OBJ_MAX_SPEED  16'h2032
`define PCS_OBJ_I2T        16'h203b
`define PCS_OBJ_ENC_ALIGN  16'h2050
`define PCS_OBJ_ENC_RES    16'h2052
`define PCS_OBJ_ENC_CFG    16'h2059
`endif

// ===== pkg/pcs_pkg.sv
package pcs_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    PCS_IDLE,
    PCS_SAVE,
    PCS_DISCARD,
    PCS_RESTART,
    PCS_LOAD
  } pcs_state_t;
  // command kinds written by the master
  typedef enum logic [1:0] {
    PCS_CMD_NONE,
    PCS_CMD_SAVE,
    PCS_CMD_DISCARD
  } pcs_cmd_t;
endpackage

// ===== rtl/pcs_store.sv
`timescale 1ns/1ns
`include "pcs_params.svh"
// Summary of operation
// - save signature stores that category only
// - finished save writes 1 into subindex
// - subindex 01 all, 02..06 single categories
// - discard signature deletes matching category data
// - discard-all keeps tuning; 06 clears tuning
// - discard ends with automatic restart
// - savable object writes clear modification markers
// - markers writable, saved with save-all
// - application category holds motion objects
// - drive holds submode; tuning motor data
// - only whole categories stored, never others
// - restart after discard reloads saved values; rstn clears the stored image
module pcs_store #(
  parameter int SAVE_CYCLES = 16                // cycles a store operation occupies the memory
) (
  input  wire logic        clk_sys,             // system clock, 20 MHz
  input  wire logic        rstn,                // asynchronous reset, active low
  input  wire logic        od_wr,               // one-cycle object dictionary write strobe
  input  wire logic [15:0] od_index,            // object index of the write
  input  wire logic [7:0]  od_sub,              // subindex of the write
  input  wire logic [31:0] od_wdata,            // write value
  input  wire logic        od_savable,          // written object belongs to some category
  input  wire logic [7:0]  rd_sub,              // subindex looked up on the read port
  output logic      [31:0] save_rdata_reg,      // save command entry at rd_sub
  output logic      [31:0] discard_rdata_reg,   // discard command entry at rd_sub
  output logic      [31:0] marker0_reg,         // modification marker, first entry
  output logic      [31:0] marker1_reg,         // modification marker, second entry
  output logic      [4:0]  store_mask_reg,      // categories being saved, one bit each
  output logic      [4:0]  erase_mask_reg,      // categories being discarded
  output logic      [4:0]  load_mask_reg,       // categories reloaded after reset
  output logic             busy_reg,            // a save or discard is running
  output logic             restart_reg          // one-cycle restart request to the controller
);
  // object indices of the command and marker entries
  localparam logic [15:0] IDX_SAVE    = `PCS_IDX_SAVE;
  localparam logic [15:0] IDX_DISCARD = `PCS_IDX_DISCARD;
  localparam logic [15:0] IDX_MARKER  = `PCS_IDX_MARKER;

  pcs_pkg::pcs_state_t state_reg;               // sequencer state
  logic [31:0] save_ent [1:6];                  // save command entries per subindex
  logic [31:0] disc_ent [1:6];                  // discard command entries per subindex
  logic [7:0]  op_sub_reg;                      // subindex that started the running save
  logic [15:0] cnt_reg;                         // store operation timer
  logic [4:0]  saved_reg;                       // categories with valid stored data
  logic [31:0] mark0_nv_reg;                    // marker copies kept with the saved data
  logic [31:0] mark1_nv_reg;

  // decode of the incoming write
  wire sub_ok   = (od_sub >= `PCS_SUB_ALL) && (od_sub <= `PCS_SUB_TUNE);
  wire wr_save  = od_wr && (od_index == IDX_SAVE) && sub_ok;
  wire wr_disc  = od_wr && (od_index == IDX_DISCARD) && sub_ok;
  wire wr_mark  = od_wr && (od_index == IDX_MARKER);
  wire idle     = (state_reg == pcs_pkg::PCS_IDLE);
  wire go_save  = wr_save && idle && (od_wdata == `PCS_SIG_SAVE);
  wire go_disc  = wr_disc && idle && (od_wdata == `PCS_SIG_DISCARD);
  // fixed category membership of well-known objects; owners of all other
  // objects flag membership on od_savable, so this list need not be complete
  wire obj_appl  = (od_index == `PCS_OBJ_OLCR_IDLE) || (od_index == `PCS_OBJ_OLCR_VAL)
                   || (od_index == `PCS_OBJ_BRAKE) || (od_index == `PCS_OBJ_CTRLWORD)
                   || (od_index == `PCS_OBJ_OPMODE) || (od_index == `PCS_OBJ_HOMING)
                   || (od_index == `PCS_OBJ_MAXACC) || (od_index == `PCS_OBJ_DOUT);
  wire obj_drive = (od_index == `PCS_OBJ_SUBMODE);
  wire obj_tune  = ((od_index >= `PCS_OBJ_POLE_PAIRS) && (od_index <= `PCS_OBJ_MAX_SPEED))
                   || (od_index == `PCS_OBJ_I2T)
                   || ((od_index >= `PCS_OBJ_ENC_ALIGN) && (od_index <= `PCS_OBJ_ENC_RES))
                   || (od_index == `PCS_OBJ_ENC_CFG);
  // objects outside every category never count as savable
  wire savable   = od_savable || obj_appl || obj_drive || obj_tune;
  // writes to save-all and to the marker itself leave markers alone
  wire mark_clr = od_wr && !wr_mark && (savable || wr_save || wr_disc)
                  && !(wr_save && od_sub == `PCS_SUB_ALL);
  wire timer_done = (cnt_reg == 16'(SAVE_CYCLES - 1));

  // subindex to category mask; discard-all spares tuning
  function automatic logic [4:0] cat_mask(input logic [7:0] sub, input logic disc);
    logic [4:0] m;
    m = `PCS_MASK_NONE;
    if (sub == `PCS_SUB_ALL)
      m = disc ? `PCS_MASK_FACTORY : `PCS_MASK_ALL;
    else if (sub >= `PCS_SUB_COMM && sub <= `PCS_SUB_TUNE)
      m = 5'(1 << (sub - `PCS_SUB_COMM));
    return m;
  endfunction

  // command entries: done value written back when the save ends
  genvar g;
  generate
    for (g = 1; g <= 6; g++) begin : g_ent
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          save_ent[g] <= `PCS_MARK_CLR;
          disc_ent[g] <= `PCS_MARK_CLR;
        end else begin
          if (state_reg == pcs_pkg::PCS_SAVE && timer_done && op_sub_reg == 8'(g))
            save_ent[g] <= `PCS_DONE_VAL;
          else if (wr_save && od_sub == 8'(g))
            save_ent[g] <= od_wdata;
          if (wr_disc && od_sub == 8'(g))
            disc_ent[g] <= od_wdata;
        end
      end
    end
  endgenerate

  // read port selection
  wire [31:0] save_rd = (rd_sub >= `PCS_SUB_ALL && rd_sub <= `PCS_SUB_TUNE) ? save_ent[rd_sub[2:0]] : 32'h0;
  wire [31:0] disc_rd = (rd_sub >= `PCS_SUB_ALL && rd_sub <= `PCS_SUB_TUNE) ? disc_ent[rd_sub[2:0]] : 32'h0;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      save_rdata_reg    <= 32'h0;
      discard_rdata_reg <= 32'h0;
    end else begin
      save_rdata_reg    <= save_rd;
      discard_rdata_reg <= disc_rd;
    end
  end

  // markers: the load cycle wins, then a master write; any other savable write clears them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      marker0_reg <= `PCS_MARK_CLR;
      marker1_reg <= `PCS_MARK_CLR;
    end else if (state_reg == pcs_pkg::PCS_LOAD) begin
      marker0_reg <= mark0_nv_reg;
      marker1_reg <= mark1_nv_reg;
    end else if (wr_mark && od_sub == `PCS_MARK_SUB0) begin
      marker0_reg <= od_wdata;
    end else if (wr_mark && od_sub == `PCS_MARK_SUB1) begin
      marker1_reg <= od_wdata;
    end else if (mark_clr) begin
      marker0_reg <= `PCS_MARK_CLR;
      marker1_reg <= `PCS_MARK_CLR;
    end
  end

  // sequencer; the stored image here stands in for the nonvolatile array and
  // models only which categories hold data and the two marker copies, since the objects live elsewhere
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= pcs_pkg::PCS_LOAD;
      op_sub_reg     <= 8'h00;
      cnt_reg        <= 16'h0;
      store_mask_reg <= `PCS_MASK_NONE;
      erase_mask_reg <= `PCS_MASK_NONE;
      load_mask_reg  <= `PCS_MASK_NONE;
      busy_reg       <= 1'b0;
      restart_reg    <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      case (state_reg)
        pcs_pkg::PCS_LOAD: begin
          load_mask_reg <= saved_reg;
          state_reg     <= pcs_pkg::PCS_IDLE;
        end
        pcs_pkg::PCS_IDLE: begin
          cnt_reg <= 16'h0;
          if (go_save) begin
            state_reg      <= pcs_pkg::PCS_SAVE;
            op_sub_reg     <= od_sub;
            store_mask_reg <= cat_mask(od_sub, 1'b0);
            busy_reg       <= 1'b1;
          end else if (go_disc) begin
            state_reg      <= pcs_pkg::PCS_DISCARD;
            erase_mask_reg <= cat_mask(od_sub, 1'b1);
            busy_reg       <= 1'b1;
          end
        end
        pcs_pkg::PCS_SAVE, pcs_pkg::PCS_DISCARD: begin
          cnt_reg <= cnt_reg + 16'h1;
          if (timer_done) begin
            store_mask_reg <= `PCS_MASK_NONE;
            erase_mask_reg <= `PCS_MASK_NONE;
            busy_reg       <= (state_reg == pcs_pkg::PCS_DISCARD);
            state_reg      <= (state_reg == pcs_pkg::PCS_DISCARD) ? pcs_pkg::PCS_RESTART : pcs_pkg::PCS_IDLE;
          end
        end
        pcs_pkg::PCS_RESTART: begin
          restart_reg <= 1'b1;
          busy_reg    <= 1'b0;
          state_reg   <= pcs_pkg::PCS_LOAD;
        end
        default: state_reg <= pcs_pkg::PCS_IDLE;
      endcase
    end
  end

  // stored image: which categories hold data, plus marker copies
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      saved_reg    <= `PCS_MASK_NONE;
      mark0_nv_reg <= `PCS_MARK_CLR;
      mark1_nv_reg <= `PCS_MARK_CLR;
    end else if (timer_done && state_reg == pcs_pkg::PCS_SAVE) begin
      saved_reg <= saved_reg | store_mask_reg;
      if (op_sub_reg == `PCS_SUB_ALL) begin
        mark0_nv_reg <= marker0_reg;
        mark1_nv_reg <= marker1_reg;
      end
    end else if (timer_done && state_reg == pcs_pkg::PCS_DISCARD) begin
      saved_reg <= saved_reg & ~erase_mask_reg;
    end
  end

  // a qualified discard is followed by the restart pulse within 300 cycles
  a_discard_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
    go_disc |-> ##[1:300] restart_reg) else $error("no restart after discard");
  // wrong signature leaves sequencer idle
  a_bad_sig_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (idle && wr_save && od_wdata != `PCS_SIG_SAVE && !go_disc) |=> idle) else $error("bad signature started op");
  // save-all does not clear the first marker
  a_saveall_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_save && od_sub == `PCS_SUB_ALL && state_reg == pcs_pkg::PCS_IDLE) |=> $stable(marker0_reg))
    else $error("save-all cleared marker");
  // discard-all never erases tuning
  a_tune_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    (go_disc && od_sub == `PCS_SUB_ALL) |=> !erase_mask_reg[`PCS_CAT_TUNE]) else $error("tuning erased");
  // a qualified save raises busy with a non-empty category mask
  a_save_start: assert property (@(posedge clk_sys) disable iff (!rstn)
    go_save |=> (busy_reg && store_mask_reg != `PCS_MASK_NONE)) else $error("save did not start");
  // end of a save: the written subindex then holds the done value
  sequence s_save_end;
    (state_reg == pcs_pkg::PCS_SAVE) && timer_done;
  endsequence
  a_save_done_val: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_save_end |=> (save_ent[op_sub_reg[2:0]] == `PCS_DONE_VAL)) else $error("save entry not set to done");
  // a savable write outside the load cycle clears both markers
  a_marker_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mark_clr && state_reg != pcs_pkg::PCS_LOAD) |=> (marker0_reg == `PCS_MARK_CLR && marker1_reg == `PCS_MARK_CLR))
    else $error("markers not cleared");
  // restart request is a single-cycle pulse
  a_restart_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    restart_reg |=> !restart_reg) else $error("restart pulse too long");
endmodule

// ===== verification/parameter_category_store_tb.sv
`timescale 1ns/1ns
`include "pcs_params.svh"
module parameter_category_store_tb;
  localparam int SC = 4;            // short store time keeps the run brief
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  rd_sub = 8'h00;
  logic        od_wr, od_savable, busy_reg, restart_reg;
  logic [15:0] od_index;
  logic [7:0]  od_sub;
  logic [31:0] od_wdata, save_rdata_reg, discard_rdata_reg, marker0_reg, marker1_reg;
  logic [4:0]  store_mask_reg, erase_mask_reg, load_mask_reg;
  int          n_errors = 0, check_count = 0, cyc = 0, n;
  logic [4:0]  smask [0:5] = '{5'h1f, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  always #25 clk_sys = ~clk_sys;
  pcs_store #(.SAVE_CYCLES(SC)) dut (.clk_sys(clk_sys), .rstn(rstn), .od_wr(od_wr), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_savable(od_savable), .rd_sub(rd_sub),
    .save_rdata_reg(save_rdata_reg), .discard_rdata_reg(discard_rdata_reg), .marker0_reg(marker0_reg),
    .marker1_reg(marker1_reg), .store_mask_reg(store_mask_reg), .erase_mask_reg(erase_mask_reg),
    .load_mask_reg(load_mask_reg), .busy_reg(busy_reg), .restart_reg(restart_reg));
  pcs_master u_m (.clk_sys(clk_sys), .busy_reg(busy_reg), .od_wr(od_wr), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_savable(od_savable));
  // verdict in one place
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // compare and report
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // registered read port: one cycle after the subindex is set
  task automatic rd(input logic [7:0] s);
    @(posedge clk_sys);
    rd_sub <= s;
    @(posedge clk_sys);
    #1;
  endtask
  // hang guard, generous against the hundred or so cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("busy_rst", {31'h0, busy_reg}, 32'h0);
    chk("load_rst", {27'h0, load_mask_reg}, 32'h0);
    $display("test reset done");
    // every save subindex, mask, duration and completion value
    for (int i = 0; i < 6; i++) begin
      u_m.put(16'h1010, 8'(i + 1), `PCS_SIG_SAVE, 1'b0);
      chk("save_busy", {31'h0, busy_reg}, 32'h1);
      chk("store_mask", {27'h0, store_mask_reg}, {27'h0, smask[i]});
      u_m.wait_idle(n);
      chk("save_len", 32'(n), 32'(SC));
      rd(8'(i + 1));
      chk("save_done", save_rdata_reg, `PCS_DONE_VAL);
    end
    $display("test save done");
    // wrong signature and out-of-range subindex start nothing
    u_m.put(16'h1010, `PCS_SUB_APPL, 32'h12345678, 1'b0);
    chk("bad_sig_busy", {31'h0, busy_reg}, 32'h0);
    rd(`PCS_SUB_APPL);
    chk("bad_sig_entry", save_rdata_reg, 32'h12345678);
    u_m.put(16'h1010, 8'h07, `PCS_SIG_SAVE, 1'b0);
    chk("sub7_busy", {31'h0, busy_reg}, 32'h0);
    u_m.put(16'h1011, `PCS_SUB_COMM, 32'h5a5a5a5a, 1'b0);
    chk("bad_disc_busy", {31'h0, busy_reg}, 32'h0);
    rd(`PCS_SUB_COMM);
    chk("disc_entry", discard_rdata_reg, 32'h5a5a5a5a);
    $display("test refuse done");
    // marker written, kept by save-all, cleared by a savable write
    u_m.put(16'h1020, 8'h01, 32'h00c0ffee, 1'b1);
    chk("marker_wr", marker0_reg, 32'h00c0ffee);
    u_m.put(16'h1020, 8'h02, 32'h00001234, 1'b1);
    chk("marker1_wr", marker1_reg, 32'h00001234);
    chk("marker0_kept", marker0_reg, 32'h00c0ffee);
    u_m.put(16'h1010, `PCS_SUB_ALL, `PCS_SIG_SAVE, 1'b0);
    chk("marker_keep", marker0_reg, 32'h00c0ffee);
    u_m.wait_idle(n);
    u_m.put(16'h6040, 8'h00, 32'h00000006, 1'b1);
    chk("marker0_clr", marker0_reg, `PCS_MARK_CLR);
    chk("marker1_clr", marker1_reg, `PCS_MARK_CLR);
    // built-in category decode: listed objects clear, uncategorised ones do not
    u_m.put(16'h1020, 8'h01, 32'h00c0ffee, 1'b1);
    u_m.put(16'h6041, 8'h00, 32'h00000000, 1'b0);
    chk("marker_uncat", marker0_reg, 32'h00c0ffee);
    u_m.put(16'h3202, 8'h00, 32'h00000001, 1'b0);
    chk("marker_drive", marker0_reg, `PCS_MARK_CLR);
    u_m.put(16'h1020, 8'h01, 32'h00c0ffee, 1'b1);
    u_m.put(16'h2038, 8'h01, 32'h00000010, 1'b0);
    chk("marker_appl", marker0_reg, `PCS_MARK_CLR);
    u_m.put(16'h1020, 8'h01, 32'h00c0ffee, 1'b1);
    u_m.put(16'h2059, 8'h00, 32'h00000000, 1'b0);
    chk("marker_tune", marker0_reg, `PCS_MARK_CLR);
    $display("test marker done");
    // discard-all spares tuning, then discard tuning; restart and reload follow
    for (int j = 0; j < 2; j++) begin
      u_m.put(16'h1011, j ? `PCS_SUB_TUNE : `PCS_SUB_ALL, `PCS_SIG_DISCARD, 1'b0);
      chk("erase_mask", {27'h0, erase_mask_reg}, j ? 32'h10 : 32'h0f);
      n = 0;
      while (restart_reg !== 1'b1 && n < 100) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk("restart_at", 32'(n), 32'(SC + 1));
      repeat (2) @(posedge clk_sys);
      #1;
      chk("reload_mask", {27'h0, load_mask_reg}, j ? 32'h00 : 32'h10);
      chk("idle_after", {31'h0, busy_reg}, 32'h0);
    end
    // after the restart the markers hold what save-all stored
    chk("marker0_reload", marker0_reg, 32'h00c0ffee);
    chk("marker1_reload", marker1_reg, 32'h00001234);
    $display("test discard done");
    conclude();
  end
endmodule

// ===== verification/pcs_master.sv
`timescale 1ns/1ns
// far-side master: one object write per call, then waits politely
module pcs_master (
  input  wire logic        clk_sys,
  input  wire logic        busy_reg,
  output logic             od_wr,
  output logic      [15:0] od_index,
  output logic      [7:0]  od_sub,
  output logic      [31:0] od_wdata,
  output logic             od_savable
);
  // quiet bus at time zero
  initial begin
    od_wr = 1'b0;
    od_index = 16'h0000;
    od_sub = 8'h00;
    od_wdata = 32'h00000000;
    od_savable = 1'b0;
  end
  // one-cycle strobe; qualifiers inverted after release so a stale value never looks valid
  task automatic put(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] dat, input logic sav);
    @(posedge clk_sys);
    od_wr <= 1'b1;
    od_index <= idx;
    od_sub <= sub;
    od_wdata <= dat;
    od_savable <= sav;
    @(posedge clk_sys);
    od_wr <= 1'b0;
    od_index <= ~idx;
    od_sub <= ~sub;
    od_wdata <= ~dat;
    od_savable <= ~sav;
    #1;
  endtask
  // no new command until the running one is over, bounded wait
  task automatic wait_idle(output int n);
    n = 0;
    while (busy_reg !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
endmodule
